/* hdl/ivpm_pkg.sv */
// Constants, register map and types of the interrupt vector and priority map.
// Assumes a single 100 MHz core clock and a word-wide AHB-Lite register port.
package ivpm_pkg;

	////////////////////////////////////////////////////////////////////////////
	// Request space
	localparam int NUM_REQ = 24;
	localparam int LVL_W = 2;
	localparam int FLD_PER_REG = 4;
	localparam int NUM_LVL_REG = 6;
	localparam logic [7:0] LVL_RST = 8'hFF;
	localparam logic [15:0] VEC_TOP_HI = 16'hFFFA;
	localparam logic [23:0] UNUSED_MASK = 24'h63FE10;

	////////////////////////////////////////////////////////////////////////////
	// Request numbers of the sources
	localparam int REQ_EXT4 = 0;
	localparam int REQ_EXT5 = 1;
	localparam int REQ_EXT26 = 2;
	localparam int REQ_EXT37 = 3;
	localparam int REQ_TMR_LO = 5;
	localparam int REQ_TMR_HI = 6;
	localparam int REQ_SER_RX = 7;
	localparam int REQ_SER_TX = 8;
	localparam int REQ_ADC = 18;
	localparam int REQ_TBT = 19;
	localparam int REQ_WATCH = 20;
	localparam int REQ_FLASH = 23;

	////////////////////////////////////////////////////////////////////////////
	// Register byte offsets; level register k sits at OFS_LVL_BASE + 4k
	localparam logic [7:0] OFS_LVL_BASE = 8'h00;
	localparam logic [7:0] OFS_STATUS = 8'h18;
	localparam logic [7:0] OFS_CLEAR = 8'h1C;
	localparam logic [7:0] OFS_ENABLE = 8'h20;
	localparam logic [7:0] OFS_ACTIVE = 8'h24;
	localparam logic [23:0] ENABLE_RST = 24'h000000;
	localparam logic [23:0] STATUS_RST = 24'h000000;

	////////////////////////////////////////////////////////////////////////////
	// Bus slave states
	typedef enum logic [1:0] {
		ST_ADDR = 2'b01,
		ST_DATA = 2'b10
	} bus_st_t;

endpackage : ivpm_pkg

/* hdl/prio_if.sv */
// Carrier between the map and its priority resolver.
// Assumes ivpm_pkg is compiled first.
`timescale 1ns/1ns
interface prio_if;
	logic [ivpm_pkg::NUM_REQ-1:0] pend;
	logic [ivpm_pkg::NUM_REQ*ivpm_pkg::LVL_W-1:0] lvl;
	logic found;
	logic [4:0] num;
	logic [ivpm_pkg::LVL_W-1:0] level;

	modport req (output pend, output lvl, input found, input num, input level);
	modport res (input pend, input lvl, output found, output num, output level);
endinterface : prio_if

/* hdl/prio_resolve.sv */
// Combinational winner search over pending requests.
// Assumes pend and lvl are stable flops of the caller.
`timescale 1ns/1ns
module prio_resolve (
	// Requests and levels in, winner out
	prio_if.res p
);
	import ivpm_pkg::*;

	// Downward scan with <= lets the lower number take a tie
	always_comb begin
		logic f;
		logic [4:0] n;
		logic [LVL_W-1:0] l;
		f = 1'b0;
		n = 5'h00;
		l = {LVL_W{1'b1}};
		for (int i = NUM_REQ - 1; i >= 0; i--) begin
			if (p.pend[i] && (!f || p.lvl[i*LVL_W +: LVL_W] <= l)) begin // [R03]
				f = 1'b1;
				n = 5'(i);
				l = p.lvl[i*LVL_W +: LVL_W];
			end
		end
		p.found = f;
		p.num = n;
		p.level = l;
	end

endmodule : prio_resolve

/* hdl/interrupt_vector_priority_map.sv */
// Interrupt request map, level registers and priority selection to the core.
// Assumes requests are levels synchronous to CLK and an AHB-Lite master.
//
// Contract
// [R01] Each of the 24 request numbers has its own two-bit level field, request n using field n.
// [R02] Request 0 vectors at FFFA (upper) and FFFB (lower), each later number two addresses lower.
// [R03] Among pending requests of equal level the lowest request number is served first.
// [R04] External channel 5 raises request 1, vector FFF8/FFF9.
// [R05] External channels 2 and 6 together drive request 2, vector FFF6/FFF7.
// [R06] External channels 3 and 7 together drive request 3, vector FFF4/FFF5.
// [R07] Timer lower half raises request 5 and upper half request 6, separately.
// [R08] Serial reception raises request 7 and transmission request 8.
// [R09] The A/D converter raises request 18, vector FFD6/FFD7.
// [R10] The timebase timer raises request 19 and the watch prescaler request 20.
// [R11] Flash memory raises request 23, vector FFCC/FFCD.
// [R12] Requests 4, 9 to 17, 21 and 22 have no source and are never asserted.
// [R13] Every 8-bit level register resets to all ones.
// [R14] Four level fields pack into each level register, lowest number in the low bits.
// [R15] A request goes to the core only if its level value is below the core's current level.
//
// The AHB-Lite register port and the address map were left to the implementer.
`timescale 1ns/1ns
module interrupt_vector_priority_map (
	// Clock and reset
	input wire logic CLK,
	input wire logic NRST,
	// AHB-Lite slave
	input wire logic HSEL,
	input wire logic [31:0] HADDR,
	input wire logic [1:0] HTRANS,
	input wire logic HWRITE,
	input wire logic [2:0] HSIZE,
	input wire logic [31:0] HWDATA,
	input wire logic HREADY,
	output logic [31:0] HRDATA,
	output logic HREADYOUT,
	output logic HRESP,
	// Peripheral request lines
	input wire logic [7:2] EXT_CH,
	input wire logic TMR_LO,
	input wire logic TMR_HI,
	input wire logic SER_RX,
	input wire logic SER_TX,
	input wire logic ADC,
	input wire logic TBT,
	input wire logic WATCH,
	input wire logic FLASH,
	// Core side
	input wire logic [ivpm_pkg::LVL_W-1:0] CPU_ILM,
	output logic IRQ_REQ,
	output logic [4:0] IRQ_NUM,
	output logic [ivpm_pkg::LVL_W-1:0] IRQ_LEVEL,
	output logic [15:0] VEC_HI_ADDR,
	output logic [15:0] VEC_LO_ADDR,
	output logic INT
);
	import ivpm_pkg::*;

	////////////////////////////////////////////////////////////////////////////
	// Declarations
	bus_st_t st_r;
	logic hready_r;
	logic [31:0] hrdata_r;
	logic wr_r;
	logic in_rng_r;
	logic [7:0] addr_r;
	logic wr_fire;
	logic lvl_hit;
	logic [2:0] lvl_idx;
	logic [31:0] rd_val;
	logic [7:0] lvl_r [NUM_LVL_REG];
	logic [NUM_REQ*LVL_W-1:0] lvl_flat;
	logic [NUM_REQ-1:0] req_line;
	logic [NUM_REQ-1:0] status_r;
	logic [NUM_REQ-1:0] status_nxt;
	logic [NUM_REQ-1:0] clr_vec;
	logic [NUM_REQ-1:0] enable_r;
	logic [NUM_REQ-1:0] pend;
	logic irq_req_r;
	logic [4:0] irq_num_r;
	logic [LVL_W-1:0] irq_lvl_r;
	logic [15:0] vec_hi_r;
	logic [15:0] vec_lo_r;
	logic int_r;

	prio_if pi();

	prio_resolve u_res (
		.p(pi.res)
	);

	////////////////////////////////////////////////////////////////////////////
	// Source to request number map
	always_comb begin
		req_line = '0;
		req_line[REQ_EXT4] = EXT_CH[4];
		req_line[REQ_EXT5] = EXT_CH[5]; // [R04]
		req_line[REQ_EXT26] = EXT_CH[2] | EXT_CH[6]; // [R05]
		req_line[REQ_EXT37] = EXT_CH[3] | EXT_CH[7]; // [R06]
		req_line[REQ_TMR_LO] = TMR_LO; // [R07]
		req_line[REQ_TMR_HI] = TMR_HI; // [R07]
		req_line[REQ_SER_RX] = SER_RX; // [R08]
		req_line[REQ_SER_TX] = SER_TX; // [R08]
		req_line[REQ_ADC] = ADC; // [R09]
		req_line[REQ_TBT] = TBT; // [R10]
		req_line[REQ_WATCH] = WATCH; // [R10]
		req_line[REQ_FLASH] = FLASH; // [R11]
		// Sourceless numbers stay low; their fields still exist
		req_line = req_line & ~UNUSED_MASK; // [R12]
	end

	////////////////////////////////////////////////////////////////////////////
	// AHB-Lite slave, one wait state on every transfer
	// The wait state keeps a read right after a write from returning stale data
	always_ff @(posedge CLK) begin
		if (!NRST) begin
			st_r <= ST_ADDR;
			hready_r <= 1'b1;
			wr_r <= 1'b0;
			in_rng_r <= 1'b0;
			addr_r <= 8'h00;
		end else begin
			unique case (st_r)
				ST_ADDR: begin
					if (HSEL && HTRANS[1] && HREADY) begin
						st_r <= ST_DATA;
						hready_r <= 1'b0;
						wr_r <= HWRITE;
						in_rng_r <= (HADDR[31:8] == 24'h000000) && (HADDR[1:0] == 2'h0);
						addr_r <= HADDR[7:0];
					end
				end
				ST_DATA: begin
					st_r <= ST_ADDR;
					hready_r <= 1'b1;
				end
			endcase
		end
	end

	always_ff @(posedge CLK) begin
		if (!NRST) begin
			hrdata_r <= 32'h00000000;
		end else if (st_r == ST_DATA && !wr_r) begin
			hrdata_r <= rd_val;
		end
	end

	assign wr_fire = (st_r == ST_DATA) && wr_r && in_rng_r;
	assign lvl_idx = addr_r[4:2];
	assign lvl_hit = (addr_r[7:5] == OFS_LVL_BASE[7:5]) && (lvl_idx < 3'(NUM_LVL_REG));

	// Unmapped offsets read as zero
	always_comb begin
		rd_val = 32'h00000000;
		if (in_rng_r) begin
			if (lvl_hit) begin
				rd_val = {24'h000000, lvl_r[lvl_idx]}; // [R14]
			end else if (addr_r == OFS_STATUS) begin
				rd_val = {8'h00, status_r};
			end else if (addr_r == OFS_ENABLE) begin
				rd_val = {8'h00, enable_r};
			end else if (addr_r == OFS_ACTIVE) begin
				rd_val = {24'h000000, irq_req_r, irq_lvl_r, irq_num_r};
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Level registers
	always_ff @(posedge CLK) begin
		if (!NRST) begin
			for (int k = 0; k < NUM_LVL_REG; k++) begin
				lvl_r[k] <= LVL_RST; // [R13]
			end
		end else if (wr_fire && lvl_hit) begin
			lvl_r[lvl_idx] <= HWDATA[7:0]; // [R14]
		end
	end

	// Field n of request n: register n/4, bits 2*(n%4)
	genvar g;
	generate
		for (g = 0; g < NUM_LVL_REG; g++) begin : g_lvl
			assign lvl_flat[g*FLD_PER_REG*LVL_W +: FLD_PER_REG*LVL_W] = lvl_r[g]; // [R01] [R14]
		end
	endgenerate

	////////////////////////////////////////////////////////////////////////////
	// Sticky status, enable and clear
	assign clr_vec = (wr_fire && addr_r == OFS_CLEAR) ? HWDATA[NUM_REQ-1:0] : '0;
	// A request in the clearing cycle survives the clear
	assign status_nxt = (status_r & ~clr_vec) | req_line;

	always_ff @(posedge CLK) begin
		if (!NRST) begin
			status_r <= STATUS_RST;
		end else begin
			status_r <= status_nxt;
		end
	end

	always_ff @(posedge CLK) begin
		if (!NRST) begin
			enable_r <= ENABLE_RST;
		end else if (wr_fire && addr_r == OFS_ENABLE) begin
			enable_r <= HWDATA[NUM_REQ-1:0] & ~UNUSED_MASK;
		end
	end

	assign pend = status_r & enable_r;

	always_ff @(posedge CLK) begin
		if (!NRST) begin
			int_r <= 1'b0;
		end else begin
			int_r <= |pend;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Selection and forwarding to the core
	assign pi.pend = pend;
	assign pi.lvl = lvl_flat; // [R01]

	// Vector outputs track the best pending request even when it is held back
	always_ff @(posedge CLK) begin
		if (!NRST) begin
			irq_req_r <= 1'b0;
			irq_num_r <= 5'h00;
			irq_lvl_r <= {LVL_W{1'b1}};
			vec_hi_r <= VEC_TOP_HI;
			vec_lo_r <= VEC_TOP_HI | 16'h0001;
		end else begin
			irq_req_r <= pi.found && (pi.level < CPU_ILM); // [R15]
			irq_num_r <= pi.num;
			irq_lvl_r <= pi.level;
			vec_hi_r <= VEC_TOP_HI - {10'h000, pi.num, 1'b0}; // [R02]
			vec_lo_r <= (VEC_TOP_HI - {10'h000, pi.num, 1'b0}) | 16'h0001; // [R02]
		end
	end

	assign HRDATA = hrdata_r;
	assign HREADYOUT = hready_r;
	assign HRESP = 1'b0;
	assign IRQ_REQ = irq_req_r;
	assign IRQ_NUM = irq_num_r;
	assign IRQ_LEVEL = irq_lvl_r;
	assign VEC_HI_ADDR = vec_hi_r;
	assign VEC_LO_ADDR = vec_lo_r;
	assign INT = int_r;

	////////////////////////////////////////////////////////////////////////////
	// Checks
	logic better;

	// Any pending request that should have beaten the resolver's choice
	always_comb begin
		better = 1'b0;
		for (int i = 0; i < NUM_REQ; i++) begin
			if (pend[i] && (lvl_flat[i*LVL_W +: LVL_W] < pi.level ||
				(lvl_flat[i*LVL_W +: LVL_W] == pi.level && 5'(i) < pi.num))) begin
				better = 1'b1;
			end
		end
	end

	default clocking cb @(posedge CLK); endclocking
	default disable iff (!NRST);

	a_vec_upper_map: assert property ( // [R02]
		IRQ_REQ |-> (VEC_HI_ADDR == 16'hFFFA - {10'h000, IRQ_NUM, 1'b0}))
		else $error("upper vector address does not match request number");

	a_vec_lower_pair: assert property ( // [R02]
		VEC_LO_ADDR == VEC_HI_ADDR + 16'h0001)
		else $error("lower vector byte is not upper plus one");

	a_tie_lowest_wins: assert property ( // [R03]
		pi.found |-> !better)
		else $error("a lower number or level request was passed over");

	a_ch5_request: assert property ( // [R04]
		EXT_CH[5] |=> status_r[1])
		else $error("channel 5 did not raise request 1");

	a_shared_ch26: assert property ( // [R05]
		(EXT_CH[2] || EXT_CH[6]) |=> status_r[2])
		else $error("channel 2 or 6 did not raise request 2");

	a_shared_ch37: assert property ( // [R06]
		(EXT_CH[3] || EXT_CH[7]) |=> status_r[3])
		else $error("channel 3 or 7 did not raise request 3");

	a_timer_halves: assert property ( // [R07]
		(TMR_LO && !TMR_HI && !status_r[6]) |=> (status_r[5] && !status_r[6]))
		else $error("timer lower half did not map to request 5 alone");

	a_flash_vector: assert property ( // [R11]
		(IRQ_REQ && IRQ_NUM == 5'd23) |-> (VEC_HI_ADDR == 16'hFFCC && VEC_LO_ADDR == 16'hFFCD))
		else $error("flash request vector is wrong");

	a_unused_quiet: assert property ( // [R12]
		(status_r & 24'h63FE10) == 24'h000000)
		else $error("a sourceless request became pending");

	a_level_reset: assert property ( // [R13]
		!$past(NRST) |-> (lvl_flat == {NUM_REQ*LVL_W{1'b1}}))
		else $error("level registers not all ones after reset");

	a_level_gate: assert property ( // [R15]
		IRQ_REQ |-> (IRQ_LEVEL < $past(CPU_ILM)))
		else $error("request forwarded without outranking core level");

	a_forward_due: assert property ( // [R15]
		(pi.found && pi.level < CPU_ILM) |=> IRQ_REQ)
		else $error("eligible request not forwarded");

	a_set_beats_clear: assert property (
		(clr_vec[7] && SER_RX) |=> status_r[7])
		else $error("request lost in its clearing cycle");

	a_adc_request: assert property ( // [R09]
		ADC |=> status_r[REQ_ADC])
		else $error("converter did not raise request 18");

	a_serial_split: assert property ( // [R08]
		(SER_TX && !SER_RX && !status_r[REQ_SER_RX]) |=> (status_r[REQ_SER_TX] && !status_r[REQ_SER_RX]))
		else $error("serial transmit did not map to request 8 alone");

	a_timebase_watch: assert property ( // [R10]
		(TBT && WATCH) |=> (status_r[REQ_TBT] && status_r[REQ_WATCH]))
		else $error("timebase or watch request not raised");

	a_flash_request: assert property ( // [R11]
		FLASH |=> status_r[REQ_FLASH])
		else $error("flash did not raise request 23");

	a_one_wait: assert property (
		!HREADYOUT |=> HREADYOUT)
		else $error("bus wait lasted more than one cycle");

	a_int_follows: assert property (
		(|pend) |=> INT)
		else $error("interrupt output missing while an enabled bit is set");

	c_forwarded: cover property (IRQ_REQ ##1 !IRQ_REQ);
	c_tie_two: cover property (pend[2] && pend[3] && lvl_flat[5:4] == lvl_flat[7:6]);
	c_level_write: cover property (wr_fire && lvl_hit ##2 IRQ_REQ);
	c_held_back: cover property (pi.found && !(pi.level < CPU_ILM));
	c_clear_race: cover property (clr_vec[REQ_SER_RX] && SER_RX);

endmodule : interrupt_vector_priority_map

/* bench/periph_model.sv */
// Peripheral side: turns one source vector into the request lines.
// Assumes the bench changes src just after a rising clock edge.
`timescale 1ns/1ns
module periph_model (
	// Source selection, bit per line
	input wire logic [13:0] src,
	// Request lines
	output logic [7:2] ext_ch,
	output logic tmr_lo,
	output logic tmr_hi,
	output logic ser_rx,
	output logic ser_tx,
	output logic adc,
	output logic tbt,
	output logic watch,
	output logic flash
);
	// Levels, high while a source wants service
	assign ext_ch = src[5:0];
	assign tmr_lo = src[6];
	assign tmr_hi = src[7];
	assign ser_rx = src[8];
	assign ser_tx = src[9];
	assign adc = src[10];
	assign tbt = src[11];
	assign watch = src[12];
	assign flash = src[13];
endmodule : periph_model

/* bench/tb.sv */
// Self-checking bench for the interrupt map.
// Assumes ivpm_pkg and the design files are compiled first.
`timescale 1ns/1ns
module tb;
	import ivpm_pkg::*;
	logic CLK = 0, NRST = 0, HSEL = 0, HWRITE = 0;
	logic [31:0] HADDR = 0, HWDATA = 0, HRDATA;
	logic [1:0] HTRANS = 0, CPU_ILM = 2'h3, IRQ_LEVEL;
	logic HREADYOUT, HRESP, IRQ_REQ, INT, TL, TH, SR, ST, AD, TB, WA, FL;
	logic [7:2] EXT;
	logic [4:0] IRQ_NUM;
	logic [15:0] VH, VL;
	logic [13:0] src = 0;
	logic [31:0] r;
	int n_mismatch = 0, checks = 0;
	// Request number of each source bit
	int num_of[14] = '{2, 3, 0, 1, 2, 3, 5, 6, 7, 8, 18, 19, 20, 23};

	periph_model PM (.src(src), .ext_ch(EXT), .tmr_lo(TL), .tmr_hi(TH), .ser_rx(SR), .ser_tx(ST),
		.adc(AD), .tbt(TB), .watch(WA), .flash(FL));
	interrupt_vector_priority_map DUT (.CLK(CLK), .NRST(NRST), .HSEL(HSEL), .HADDR(HADDR), .HTRANS(HTRANS),
		.HWRITE(HWRITE), .HSIZE(3'h2), .HWDATA(HWDATA), .HREADY(HREADYOUT), .HRDATA(HRDATA),
		.HREADYOUT(HREADYOUT), .HRESP(HRESP), .EXT_CH(EXT), .TMR_LO(TL), .TMR_HI(TH), .SER_RX(SR),
		.SER_TX(ST), .ADC(AD), .TBT(TB), .WATCH(WA), .FLASH(FL), .CPU_ILM(CPU_ILM), .IRQ_REQ(IRQ_REQ),
		.IRQ_NUM(IRQ_NUM), .IRQ_LEVEL(IRQ_LEVEL), .VEC_HI_ADDR(VH), .VEC_LO_ADDR(VL), .INT(INT));

	initial begin
		forever #5 CLK = ~CLK;
	end

	////////////////////////////////////////////////////////////////////////////
	task conclude;
		if (n_mismatch == 0 && checks > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask : conclude

	task chk(input logic [31:0] got, input logic [31:0] exp);
		checks++;
		if (got !== exp) begin
			n_mismatch++;
			$display("BAD %0t got %h want %h", $time, got, exp);
		end
	endtask : chk

	// Bounded wait for hready at a rising edge
	task wt;
		int n;
		n = 0;
		do begin
			@(posedge CLK);
			n++;
		end while (HREADYOUT !== 1'b1 && n < 50);
		if (HREADYOUT !== 1'b1) begin
			n_mismatch++;
			conclude();
		end
	endtask : wt

	task xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
		HSEL <= 1'b1;
		HTRANS <= 2'h2;
		HADDR <= {24'h000000, a};
		HWRITE <= w;
		wt();
		// Address phase closed: select and type go idle together
		HSEL <= 1'b0;
		HTRANS <= 2'h0;
		HWDATA <= d;
		wt();
		r = HRDATA;
		chk(HRESP, 1'b0);
	endtask : xfer

	// Request line to status, then to the core outputs
	task settle;
		repeat (3) @(posedge CLK);
		#1;
	endtask : settle

	task core(input int n, input logic [1:0] lv, input logic rq);
		chk(IRQ_NUM, n);
		chk(VH, 16'hFFFA - 16'(2 * n));
		chk(VL, 16'hFFFB - 16'(2 * n));
		chk(IRQ_LEVEL, lv);
		chk(IRQ_REQ, rq);
		chk(INT, 1'b1);
	endtask : core

	////////////////////////////////////////////////////////////////////////////
	initial begin
		repeat (10) @(posedge CLK);
		NRST <= 1'b1;
		@(posedge CLK);
		for (int k = 0; k < 6; k++) begin
			xfer(0, 8'(4 * k), 0);
			chk(r, 32'h000000FF);
		end
		chk(IRQ_LEVEL, 2'h3);
		chk(VH, 16'hFFFA);
		xfer(1, OFS_ENABLE, 32'h00FFFFFF);
		for (int k = 0; k < 6; k++) begin
			xfer(1, 8'(4 * k), 0);
		end
		// Each source alone, level 0, core at level 3
		foreach (num_of[i]) begin
			src <= 14'(1) << i;
			settle();
			core(num_of[i], 2'h0, 1'b1);
			src <= 14'h0000;
			xfer(1, OFS_CLEAR, 32'h00FFFFFF);
		end
		// Every source at once: only sourced bits ever set
		src <= 14'h3FFF;
		settle();
		xfer(0, OFS_STATUS, 0);
		chk(r, {8'h00, ~UNUSED_MASK});
		xfer(0, OFS_ENABLE, 0);
		chk(r, {8'h00, ~UNUSED_MASK});
		xfer(0, 8'hF0, 0);
		chk(r, 32'h00000000);
		// Equal levels: lowest number wins
		src <= 14'h2C00;
		xfer(1, OFS_CLEAR, 32'h00FFFFFF);
		settle();
		core(18, 2'h0, 1'b1);
		// Level 1 everywhere but request 23 at level 0
		for (int k = 0; k < 6; k++) begin
			xfer(1, 8'(4 * k), 32'h00000055);
		end
		xfer(1, 8'h14, 32'h00000015);
		xfer(0, 8'h14, 0);
		chk(r, 32'h00000015);
		settle();
		core(23, 2'h0, 1'b1);
		CPU_ILM <= 2'h0;
		settle();
		core(23, 2'h0, 1'b0);
		CPU_ILM <= 2'h1;
		src <= 14'h0400;
		xfer(1, OFS_CLEAR, 32'h00800000);
		settle();
		core(18, 2'h1, 1'b0);
		xfer(0, OFS_ACTIVE, 0);
		chk(r, {24'h000000, 1'b0, 2'h1, 5'd18});
		// Receiver held high through a full clear keeps its bit
		src <= 14'h0100;
		settle();
		xfer(1, OFS_CLEAR, 32'h00FFFFFF);
		xfer(0, OFS_STATUS, 0);
		chk(r, 32'h00000080);
		// Reset in mid-run brings back the default levels
		NRST <= 1'b0;
		src <= 14'h0000;
		repeat (2) @(posedge CLK);
		NRST <= 1'b1;
		@(posedge CLK);
		#1;
		chk(IRQ_REQ, 1'b0);
		chk(INT, 1'b0);
		chk(IRQ_LEVEL, 2'h3);
		for (int k = 0; k < 6; k++) begin
			xfer(0, 8'(4 * k), 0);
			chk(r, 32'h000000FF);
		end
		conclude();
	end
endmodule : tb
